// ===== dsq_dma_model.sv
// Purpose: dma controller model draining results
// Assumes: done is a level request, ack a one-cycle pulse
// Notes: slow waits twenty cycles before the ack
`timescale 1ns/100ps
module dsq_dma_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic conv_done,
    input wire logic enable,
    input wire logic slow,
    output logic dma_ack
);
    // one ack pulse for each raised request
    initial
    begin
        dma_ack = 1'b0;
        forever
        begin
            @(negedge pclk);
            if (presetn && enable && conv_done === 1'b1)
            begin
                repeat (slow ? 20 : 1) @(posedge pclk);
                dma_ack <= 1'b1;
                @(posedge pclk);
                dma_ack <= 1'b0;
                @(posedge pclk);
            end
        end
    end
endmodule : dsq_dma_model

// ===== dsq_pkg.sv
// Purpose: constants and types for the delta-sigma conversion sequencer
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package dsq_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFF_RATE = 8'h18;
    // ctrl fields
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    // cfg fields
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_RES8 = 2;
    localparam int CFG_MUX_LO = 4;
    localparam int MUX_W = 4;
    // status / irq fields
    localparam int ST_DONE = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_VALID = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVR = 1;
    // priming and pipeline
    localparam int PIPE_DEPTH = 4;
    localparam logic [2:0] PRIME_CONV = 3'h3;
    localparam logic [2:0] MUX_SETTLE = 3'h4;
    // conversion length in modulator bits per result
    localparam int CLK_MHZ = 125;
    localparam int KSPS_12 = 192;
    localparam int KSPS_8 = 384;
    localparam logic [9:0] OSR_12 = 10'((CLK_MHZ * 1000) / KSPS_12);
    localparam logic [9:0] OSR_8 = 10'((CLK_MHZ * 1000) / KSPS_8);
    localparam logic [9:0] RATE_RESET = OSR_12;
    localparam logic [1:0] CFG_RESET = 2'h0;
    typedef enum logic [1:0]
    {
        MODE_SINGLE = 2'h0,
        MODE_CONT = 2'h1,
        MODE_MULTI = 2'h2,
        MODE_TURBO = 2'h3
    } dsq_mode_t;
    typedef enum logic [3:0]
    {
        ST_STANDBY = 4'b0001,
        ST_PRIME = 4'b0010,
        ST_CONVERT = 4'b0100,
        ST_HOLD = 4'b1000
    } dsq_state_t;
endpackage : dsq_pkg

// ===== dsq_sequencer.sv
// Purpose: mode sequencing and decimation for a delta-sigma converter
// Assumes: modulator bit and start strobe come from outside, synchronised
// Notes: result read over APB or by dma acknowledge clears done
`timescale 1ns/100ps
module dsq_sequencer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mod_bit,
    input wire logic start_strobe,
    input wire logic dma_ack,
    output logic conv_done,
    output logic irq,
    output logic [dsq_pkg::MUX_W-1:0] mux_sel,
    output logic mod_reset
);
    import dsq_pkg::*;

    logic [1:0] bit_sync;
    logic [1:0] soc_sync;
    logic soc_prev;
    logic [1:0] cfg_mode;
    logic cfg_res8;
    logic [MUX_W-1:0] cfg_mux;
    logic [9:0] rate;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    dsq_state_t state;
    logic [2:0] prime_cnt;
    logic [9:0] bit_cnt;
    logic [9:0] accum;
    logic [9:0] pipe [PIPE_DEPTH];
    logic [11:0] result;
    logic done;
    logic valid;
    logic [2:0] settle_cnt;
    // next values
    dsq_state_t next_state;
    logic [2:0] next_prime_cnt;
    logic [9:0] next_bit_cnt;
    logic [9:0] next_accum;
    logic [9:0] next_pipe [PIPE_DEPTH];
    logic [11:0] next_result;
    logic next_done;
    logic next_valid;
    logic [2:0] next_settle_cnt;
    logic [1:0] next_cfg_mode;
    logic next_cfg_res8;
    logic [MUX_W-1:0] next_cfg_mux;
    logic [9:0] next_rate;
    logic [1:0] next_irq_stat;
    logic [1:0] next_irq_mask;
    logic [31:0] next_prdata;
    logic next_soc_prev;

    logic wr_acc;
    logic rd_acc;
    logic start_trig;
    logic stop_req;
    logic result_read;
    logic conv_end;
    logic [9:0] osr;
    logic [11:0] sum4;
    logic mux_wr;
    logic done_evt;

    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // software start bit or rising edge of start strobe
    assign start_trig = (wr_acc && paddr == OFF_CTRL && pwdata[CTRL_START])
        || (soc_sync[1] && !soc_prev);
    assign stop_req = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_STOP];
    assign result_read = (rd_acc && paddr == OFF_RESULT) || dma_ack;
    // conversion period, clipped so 8-bit may run twice as fast
    assign osr = (rate < (cfg_res8 ? OSR_8 : OSR_12))
        ? (cfg_res8 ? OSR_8 : OSR_12) : rate;
    assign conv_end = (state != ST_STANDBY) && (state != ST_HOLD)
        && (bit_cnt == osr - 10'h1);
    assign mux_wr = wr_acc && paddr == OFF_CFG
        && pwdata[CFG_MUX_LO +: MUX_W] != cfg_mux;
    assign done_evt = conv_end && state == ST_CONVERT;
    assign conv_done = done;
    assign irq = |(irq_stat & irq_mask);
    assign mux_sel = cfg_mux;
    assign mod_reset = (state == ST_STANDBY);

    // input synchronisers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_sync <= 2'h0;
            soc_sync <= 2'h0;
        end
        else
        begin
            bit_sync <= {bit_sync[0], mod_bit};
            soc_sync <= {soc_sync[0], start_strobe};
        end
    end

    // registers and sequencing next values
    always_comb
    begin
        next_cfg_mode = cfg_mode;
        next_cfg_res8 = cfg_res8;
        next_cfg_mux = cfg_mux;
        next_rate = rate;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        next_soc_prev = soc_sync[1];
        next_prdata = prdata;
        if (wr_acc && paddr == OFF_CFG)
        begin
            next_cfg_mode = pwdata[CFG_MODE_LO +: 2];
            next_cfg_res8 = pwdata[CFG_RES8];
            next_cfg_mux = pwdata[CFG_MUX_LO +: MUX_W];
        end
        else if (wr_acc && paddr == OFF_RATE)
        begin
            next_rate = pwdata[9:0];
        end
        else if (wr_acc && paddr == OFF_IRQ_MASK)
        begin
            next_irq_mask = pwdata[1:0];
        end
        else if (wr_acc && paddr == OFF_IRQ_STAT)
        begin
            next_irq_stat = irq_stat & ~pwdata[1:0];
        end
        // set wins over write-one clear
        if (done_evt)
        begin
            next_irq_stat[IRQ_DONE] = 1'b1;
            if (done)
            begin
                next_irq_stat[IRQ_OVR] = 1'b1;
            end
        end
        // read data loaded in the setup cycle, held otherwise
        if (psel && !penable && !pwrite)
        begin
            if (paddr == OFF_CFG)
                next_prdata = {24'h0, cfg_mux, 1'b0, cfg_res8, cfg_mode};
            else if (paddr == OFF_STAT)
                next_prdata = {29'h0, valid, state != ST_STANDBY, done};
            else if (paddr == OFF_RESULT)
                next_prdata = {20'h0, result};
            else if (paddr == OFF_IRQ_STAT)
                next_prdata = {30'h0, irq_stat};
            else if (paddr == OFF_IRQ_MASK)
                next_prdata = {30'h0, irq_mask};
            else if (paddr == OFF_RATE)
                next_prdata = {22'h0, rate};
            else
                next_prdata = 32'h0;
        end
    end

    // conversion sequencing
    always_comb
    begin
        next_state = state;
        next_prime_cnt = prime_cnt;
        next_bit_cnt = bit_cnt;
        next_accum = accum;
        next_pipe = pipe;
        next_result = result;
        next_done = done;
        next_valid = valid;
        next_settle_cnt = settle_cnt;
        // done holds until read; a new result sets it again
        if (result_read)
            next_done = 1'b0;
        if (mux_wr)
        begin
            next_settle_cnt = 3'h0;
            next_valid = 1'b0;
        end
        if (state != ST_STANDBY && state != ST_HOLD)
        begin
            // one-bit stream counted into a word per period
            next_accum = accum + {9'h0, bit_sync[1]};
            next_bit_cnt = bit_cnt + 10'h1;
            if (conv_end)
            begin
                next_bit_cnt = 10'h0;
                next_accum = 10'h0;
                next_pipe[0] = accum + {9'h0, bit_sync[1]};
                for (int i = 1; i < PIPE_DEPTH; i++)
                begin
                    next_pipe[i] = pipe[i-1];
                end
                if (!mux_wr && settle_cnt < MUX_SETTLE)
                begin
                    next_settle_cnt = settle_cnt + 3'h1;
                end
            end
        end
        // four latest words, the one just finished included
        sum4 = 12'(next_pipe[0]) + 12'(next_pipe[1]) + 12'(next_pipe[2])
            + 12'(next_pipe[3]);
        case (state)
            ST_STANDBY:
            begin
                if (start_trig)
                begin
                    next_state = ST_PRIME;
                    next_prime_cnt = 3'h0;
                    next_bit_cnt = 10'h0;
                    next_accum = 10'h0;
                    next_pipe = '{default: 10'h0};
                end
            end
            ST_PRIME:
            begin
                // three priming conversions before any result
                if (conv_end)
                begin
                    next_prime_cnt = prime_cnt + 3'h1;
                    if (prime_cnt == PRIME_CONV - 3'h1)
                    begin
                        next_state = ST_CONVERT;
                    end
                end
            end
            ST_CONVERT:
            begin
                if (conv_end)
                begin
                    next_result = cfg_res8
                        ? {sum4[11:4], 4'h0} : sum4;
                    next_done = 1'b1;
                    next_valid = !mux_wr
                        && settle_cnt >= MUX_SETTLE - 3'h1;
                    case (dsq_mode_t'(cfg_mode))
                        MODE_SINGLE: next_state = ST_HOLD;
                        MODE_CONT: next_state = ST_CONVERT;
                        // re-prime from an empty pipe, restart at once
                        default:
                        begin
                            next_state = ST_PRIME;
                            next_prime_cnt = 3'h0;
                            next_pipe = '{default: 10'h0};
                        end
                    endcase
                end
            end
            ST_HOLD:
            begin
                if (result_read || !done)
                begin
                    next_state = ST_STANDBY;
                end
            end
            default: next_state = ST_STANDBY;
        endcase
        if (stop_req)
        begin
            next_state = ST_STANDBY;
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_STANDBY;
            prime_cnt <= 3'h0;
            bit_cnt <= 10'h0;
            accum <= 10'h0;
            pipe <= '{default: 10'h0};
            result <= 12'h0;
            done <= 1'b0;
            valid <= 1'b0;
            settle_cnt <= 3'h0;
            cfg_mode <= CFG_RESET;
            cfg_res8 <= 1'b0;
            cfg_mux <= '0;
            rate <= RATE_RESET;
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            prdata <= 32'h0;
            soc_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            prime_cnt <= next_prime_cnt;
            bit_cnt <= next_bit_cnt;
            accum <= next_accum;
            pipe <= next_pipe;
            result <= next_result;
            done <= next_done;
            valid <= next_valid;
            settle_cnt <= next_settle_cnt;
            cfg_mode <= next_cfg_mode;
            cfg_res8 <= next_cfg_res8;
            cfg_mux <= next_cfg_mux;
            rate <= next_rate;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            prdata <= next_prdata;
            soc_prev <= next_soc_prev;
        end
    end
endmodule : dsq_sequencer

// ===== dsq_sequencer_assertions.sv
// Purpose: port checks for the conversion sequencer
// Assumes: zero wait apb, one clock domain
// Notes: bind at the foot
`timescale 1ns/100ps
module dsq_sequencer_assertions
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mod_bit,
    input wire logic start_strobe,
    input wire logic dma_ack,
    input wire logic conv_done,
    input wire logic irq,
    input wire logic [dsq_pkg::MUX_W-1:0] mux_sel,
    input wire logic mod_reset
);
    import dsq_pkg::*;
    logic [15:0] run_cnt;
    logic [15:0] next_run_cnt;
    logic wr;
    logic rd_res;
    // cycles since leaving standby, saturating
    always_comb
    begin
        next_run_cnt = mod_reset ? 16'h0 : run_cnt + {15'h0, ~&run_cnt};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_cnt <= 16'h0;
        else
            run_cnt <= next_run_cnt;
    end
    // completed apb accesses
    assign wr = psel & penable & pwrite;
    assign rd_res = psel & penable & ~pwrite & (paddr == OFF_RESULT);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    apb_answer_a: assert property (pready && !pslverr)
        else $error("apb answer not ready or error");
    done_hold_a: assert property (conv_done && !dma_ack && !rd_res
        && !(wr && paddr == OFF_CTRL) |=> conv_done)
        else $error("done dropped before read");
    done_clear_a: assert property ((rd_res || dma_ack) |=> !conv_done)
        else $error("done kept after read");
    reset_idle_a: assert property ($rose(presetn)
        |-> mod_reset && !conv_done && !irq)
        else $error("not idle after reset");
    start_run_a: assert property (mod_reset && wr && paddr == OFF_CTRL
        && pwdata[CTRL_START] && !pwdata[CTRL_STOP] |=> !mod_reset)
        else $error("start ignored in standby");
    stop_idle_a: assert property (wr && paddr == OFF_CTRL
        && pwdata[CTRL_STOP] |=> mod_reset)
        else $error("stop did not reach standby");
    prime_len_a: assert property ($rose(conv_done)
        |-> run_cnt >= 16'd1300)
        else $error("result before priming done");
    mask_off_a: assert property (wr && paddr == OFF_IRQ_MASK
        && pwdata[1:0] == 2'h0 |=> !irq)
        else $error("irq while fully masked");
    mux_copy_a: assert property (wr && paddr == OFF_CFG
        |=> mux_sel == 4'($past(pwdata) >> CFG_MUX_LO))
        else $error("mux select not taken");
endmodule : dsq_sequencer_assertions

bind dsq_sequencer dsq_sequencer_assertions u_dsq_sequencer_assertions
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit),
    .start_strobe(start_strobe), .dma_ack(dma_ack),
    .conv_done(conv_done), .irq(irq), .mux_sel(mux_sel),
    .mod_reset(mod_reset)
);

// ===== dsq_sequencer_test.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: dma model drains results when enabled
// Notes: expectations follow from rate and mode
`timescale 1ns/100ps
module dsq_sequencer_test;
    import dsq_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mod_bit, start_strobe, dma_ack, conv_done, irq, mod_reset;
    logic dma_en, dma_slow, rnd;
    logic [MUX_W-1:0] mux_sel, mux;
    int miscompares, comparisons, cyc, t0, t1, p;
    dsq_sequencer u_dsq_sequencer (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mod_bit(mod_bit),
        .start_strobe(start_strobe), .dma_ack(dma_ack),
        .conv_done(conv_done), .irq(irq), .mux_sel(mux_sel),
        .mod_reset(mod_reset));
    dsq_dma_model u_dsq_dma_model (.pclk(pclk), .presetn(presetn),
        .conv_done(conv_done), .enable(dma_en), .slow(dma_slow),
        .dma_ack(dma_ack));
    // clock and cycle count
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (rnd)
            mod_bit <= 1'($urandom);
    end
    function automatic logic [31:0] in_win(int d, int lo, int hi);
        return {31'h0, d >= lo && d <= hi};
    endfunction : in_win
    // all-ones stream: four full periods, 8-bit keeps bits 11:4 in place
    function automatic logic [31:0] exp_res(logic r8, int per);
        return r8 ? 32'(((4 * per) >> 4) << 4) : 32'(4 * per);
    endfunction : exp_res
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (conv_done !== v && n < 20000)
        begin
            @(negedge pclk);
            n++;
        end
        if (n >= 20000)
            miscompares++;
        @(posedge pclk);
    endtask : wait_lvl
    task automatic report_and_stop;
        $display("comparisons %0d miscompares %0d", comparisons,
            miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // hang guard
    initial
    begin
        #400000;
        miscompares++;
        report_and_stop;
    end
    // main sequence
    initial
    begin
        {psel, penable, pwrite, start_strobe, dma_en, dma_slow} = 6'h0;
        {presetn, rnd, paddr, pwdata} = 42'h0;
        mod_bit = 1'b1;
        {cyc, miscompares, comparisons} = 96'h0;
        void'($urandom(32'h3e75adf0));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, OFF_STAT, 0);
        chk(rd, 32'h0);
        apb(0, OFF_RATE, 0);
        chk(rd, 32'h28b);
        apb(0, 8'h1c, 0);
        chk(rd, 32'h0);
        chk(32'(mod_reset), 32'h1);
        // single sample: register start, then strobe in 8-bit
        for (int r = 0; r < 2; r++)
        begin
            p = r ? 325 : 651;
            mux = 4'($urandom);
            apb(1, OFF_CFG, {24'h0, mux, 1'b0, r[0], 2'(MODE_SINGLE)});
            chk(32'(mux_sel), 32'(mux));
            apb(1, OFF_RATE, p);
            apb(1, OFF_IRQ_MASK, 32'h1);
            t0 = cyc;
            if (r == 0)
                apb(1, OFF_CTRL, 32'h1);
            else
            begin
                start_strobe <= 1'b1;
                repeat (4) @(posedge pclk);
                start_strobe <= 1'b0;
            end
            wait_lvl(1'b1);
            chk(in_win(cyc - t0, 4 * p, 4 * p + 12), 32'h1);
            chk(32'(irq), 32'h1);
            apb(0, OFF_STAT, 0);
            chk(rd & 32'h1, 32'h1);
            chk(rd & 32'h4, 32'h4);
            apb(0, OFF_RESULT, 0);
            chk(rd, exp_res(r[0], p));
            chk(32'(conv_done), 32'h0);
            chk(32'(mod_reset), 32'h1);
            apb(1, OFF_IRQ_STAT, 32'h1);
            chk(32'(irq), 32'h0);
        end
        // continuous, masked irq, mux left fixed
        dma_en <= 1'b1;
        dma_slow <= 1'($urandom);
        apb(1, OFF_IRQ_MASK, 32'h0);
        apb(1, OFF_RATE, 32'd651);
        apb(1, OFF_CFG, 32'(MODE_CONT));
        t0 = cyc;
        apb(1, OFF_CTRL, 32'h1);
        wait_lvl(1'b1);
        t1 = cyc;
        chk(in_win(t1 - t0, 2604, 2616), 32'h1);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        chk(in_win(cyc - t1, 649, 653), 32'h1);
        chk(32'(irq), 32'h0);
        apb(0, OFF_RESULT, 0);
        chk(rd, exp_res(1'b0, 651));
        apb(0, OFF_IRQ_STAT, 0);
        chk(rd & 32'h1, 32'h1);
        apb(1, OFF_CTRL, 32'h2);
        chk(32'(mod_reset), 32'h1);
        apb(1, OFF_IRQ_STAT, 32'h3);
        // multi and turbo restart on their own, re-primed
        dma_slow <= 1'b0;
        rnd <= 1'b1;
        for (int m = 2; m < 4; m++)
        begin
            apb(1, OFF_CFG, 32'(m));
            apb(1, OFF_CTRL, 32'h1);
            wait_lvl(1'b1);
            t1 = cyc;
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            chk(in_win(cyc - t1, 2604, 2630), 32'h1);
            apb(1, OFF_CTRL, 32'h2);
            chk(32'(mod_reset), 32'h1);
            wait_lvl(1'b0);
        end
        report_and_stop;
    end
endmodule : dsq_sequencer_test
